//--- tb/uhr_host_model.sv
`default_nettype none
// Stands in for the upstream host and the configuration EEPROM.
module uhr_host_model #(
    parameter logic [63:0] CFG = 64'hA5C3_1E2D_0100_0000
) (
    input  wire logic        sys_clk,
    input  wire logic        bus_reset,
    input  wire logic        hs_host,
    input  wire logic        chirp_k_tx,
    input  wire logic        ee_cs_n,
    input  wire logic        ee_sck,
    input  wire logic        ee_mosi,
    output logic             ee_miso,
    output logic             up_se0_line,
    output logic             up_k_line,
    output logic [15:0]      cmd_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Vendor and product codes inside CFG are arbitrary.
    logic [79:0] sr = {16'h0000, CFG};
    logic        seen_chirp;
    int          nb = 0;
    int          kj;
    always @(negedge ee_sck or posedge ee_cs_n) begin
        // The part shifts only after a rising SCK has been seen.
        if (ee_cs_n || nb == 0) begin
            sr <= {16'h0000, CFG};
        end else begin
            sr <= {sr[78:0], 1'b0};
        end
    end
    // A deselected part leaves the line floating, so show the inverse.
    assign ee_miso = ee_cs_n ? ~sr[79] : sr[79];
    always @(posedge ee_sck) begin
        if (nb < 16) begin
            cmd_seen <= {cmd_seen[14:0], ee_mosi};
        end
        nb <= nb + 1;
    end
    assign up_se0_line = bus_reset;
    always @(posedge sys_clk) begin
        if (!bus_reset) begin
            seen_chirp <= 1'b0;
            kj <= 0;
            up_k_line <= 1'b0;
        end else if (chirp_k_tx) begin
            seen_chirp <= 1'b1;
        end else if (seen_chirp && hs_host && kj < 48) begin
            kj <= kj + 1;
            if (kj % 4 == 3) begin
                up_k_line <= ~up_k_line;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/usb_hub_init_enum_tt_routing_test.sv
`default_nettype none
module usb_hub_init_enum_tt_routing_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] CFG = 64'hA5C3_1E2D_0100_0000;
    logic                      sys_clk, rst_n, vbus, bus_reset, hs_host;
    logic                      se0, kl, cs_n, sck, mosi, miso, loaded, pu;
    logic                      chirp, hs, set_a, set_c, set_i, susp;
    logic                      in_valid, in_ready, out_valid, out_ready;
    logic                      multi, up_res, suspended;
    logic [6:0]                req_a, dev_a;
    logic [7:0]                req_c, req_alt, dev_c;
    logic [3:0]                via_tt, hs_ok, pw_req, pw_en, se0_drv, dn_res;
    logic [15:0]               cmd;
    uhr_pkg::uhr_ee_cfg_t      ee_cfg;
    uhr_pkg::uhr_speed_t [3:0] spd;
    uhr_pkg::uhr_beat_t        in_beat;
    uhr_pkg::uhr_dn_beat_t     out_beat;
    int                        errors, checks, cyc;

    uhr_hub_ctrl #(.CHIRP_CYCLES(16)) i_uhr_hub_ctrl (.sys_clk(sys_clk),
        .rst_n(rst_n), .upstream_vbus_sense(vbus), .up_se0_line(se0),
        .up_k_line(kl), .ee_cs_n(cs_n), .ee_sck(sck), .ee_mosi(mosi),
        .ee_miso(miso), .cfg_loaded(loaded), .ee_cfg(ee_cfg),
        .dp_pullup_en(pu), .chirp_k_tx(chirp), .hs_mode(hs),
        .req_set_address(set_a), .req_address(req_a),
        .req_set_config(set_c), .req_config(req_c),
        .req_set_interface(set_i), .req_alt(req_alt), .dev_address(dev_a),
        .dev_config(dev_c), .multi_tt(multi), .port_speed(spd),
        .port_via_tt(via_tt), .port_hs_ok(hs_ok), .port_power_req(pw_req),
        .port_power_en(pw_en), .port_se0_drive(se0_drv),
        .suspend_req(susp), .dn_resume_line(dn_res),
        .up_resume_tx(up_res), .suspended(suspended),
        .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
        .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));
    uhr_host_model #(.CFG(CFG)) i_uhr_host_model (.sys_clk(sys_clk),
        .bus_reset(bus_reset), .hs_host(hs_host), .chirp_k_tx(chirp),
        .ee_cs_n(cs_n), .ee_sck(sck), .ee_mosi(mosi), .ee_miso(miso),
        .up_se0_line(se0), .up_k_line(kl), .cmd_seen(cmd));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Generous ceiling: the EEPROM load and two bus resets need under 1000.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [63:0] exp, got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic req(input int k, input logic [7:0] v);
        set_a = (k == 0);
        set_c = (k == 1);
        set_i = (k == 2);
        req_a = v[6:0];
        req_c = v;
        req_alt = v;
        tick(1);
        {set_a, set_c, set_i} = 3'h0;
        tick(1);
    endtask
    task automatic bus_rst(input logic hs_h);
        hs_host = hs_h;
        bus_reset = 1'b1;
        for (int i = 0; i < 20 && chirp !== 1'b1; i++) tick(1);
        chk("chirp_k_tx", 1, chirp);
        tick(100);
        bus_reset = 1'b0;
        tick(4);
    endtask
    task automatic push(input logic [1:0] p, input logic [7:0] d,
                        input logic l);
        in_beat = '{port: p, data: d, last: l};
        in_valid = 1'b1;
        for (int i = 0; i < 20 && in_ready !== 1'b1; i++) tick(1);
        tick(1);
        in_valid = 1'b0;
        tick(1);
    endtask
    task automatic pop(input string what, input logic [12:0] exp);
        out_ready = 1'b1;
        for (int i = 0; i < 20 && out_valid !== 1'b1; i++) tick(1);
        chk(what, exp, out_beat);
        tick(1);
        out_ready = 1'b0;
        tick(1);
    endtask
    task automatic t_boot;
        for (int i = 0; i < 500 && loaded !== 1'b1; i++) tick(1);
        chk("ee_cfg", CFG, ee_cfg);
        chk("ee_cmd", 16'h0300, cmd);
        tick(20);
        chk("pullup_no_vbus", 0, pu);
        vbus = 1'b1;
        tick(6);
        chk("pullup_attach", 1, pu);
        chk("port_se0", 4'hF, se0_drv);
        chk("port_power", 0, pw_en);
        chk("in_ready", 0, in_ready);
        bus_rst(1'b0);
        chk("hs_mode_fs", 0, hs);
        chk("pullup_fs", 1, pu);
        chk("port_hs_ok", 0, hs_ok);
        chk("via_tt_fs", 0, via_tt);
        $display("test boot and full-speed attach done");
    endtask
    task automatic t_enum;
        req(0, 8'h05);
        req(1, 8'h01);
        bus_rst(1'b1);
        chk("hs_mode", 1, hs);
        chk("pullup_hs", 0, pu);
        chk("addr_after_reset", 0, dev_a);
        chk("cfg_after_reset", 0, dev_c);
        req(0, 8'h05);
        req(1, 8'h01);
        chk("cfg_set", 8'h01, dev_c);
        chk("multi_default", 0, multi);
        req(2, 8'h01);
        chk("multi_alt1", 1, multi);
        req(2, 8'h02);
        chk("multi_alt2", 0, multi);
        req(0, 8'h06);
        chk("addr_new", 7'h06, dev_a);
        chk("cfg_cleared", 0, dev_c);
        req(1, 8'h01);
        chk("port_released", 0, se0_drv);
        chk("port_power_cfg", 4'hF, pw_en);
        chk("via_tt_hs", 4'h7, via_tt);
        chk("port_hs_ok_hs", 4'hF, hs_ok);
        $display("test enumeration done");
    endtask
    task automatic t_route;
        push(2'h1, 8'h3C, 1'b1);
        pop("single_tt_mask", {4'h7, 8'h3C, 1'b1});
        req(2, 8'h01);
        // Stall the receiver so both buffer entries fill before draining.
        push(2'h1, 8'h5A, 1'b0);
        push(2'h2, 8'hA5, 1'b1);
        tick(1);
        chk("in_ready_full", 0, in_ready);
        pop("multi_tt_first", {4'h2, 8'h5A, 1'b0});
        pop("multi_tt_second", {4'h2, 8'hA5, 1'b1});
        $display("test routing done");
    endtask
    task automatic t_suspend;
        susp = 1'b1;
        dn_res = 4'h2;
        tick(5);
        chk("suspended", 1, suspended);
        chk("in_ready_susp", 0, in_ready);
        chk("resume_up", 1, up_res);
        {susp, dn_res} = 5'h00;
        tick(5);
        chk("suspend_left", 0, suspended);
        $display("test suspend done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        {rst_n, vbus, bus_reset, hs_host, set_a, set_c, set_i} = 7'h00;
        {susp, in_valid, out_ready, errors, checks, cyc} = '0;
        {req_a, req_c, req_alt, dn_res} = '0;
        pw_req = 4'hF;
        in_beat = '0;
        spd[3] = uhr_pkg::UHR_SPD_HS;
        spd[2] = uhr_pkg::UHR_SPD_LS;
        spd[1] = uhr_pkg::UHR_SPD_FS;
        spd[0] = uhr_pkg::UHR_SPD_FS;
        tick(10);
        rst_n = 1'b1;
        t_boot();
        t_enum();
        t_route();
        t_suspend();
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- verilog/uhr_buf2.sv
`default_nettype none
module uhr_buf2 (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  s_valid,
    output logic                       s_ready,
    input  wire uhr_pkg::uhr_dn_beat_t s_beat,
    output logic                       m_valid,
    input  wire logic                  m_ready,
    output uhr_pkg::uhr_dn_beat_t      m_beat
);
    // Two entries let the source keep streaming for one cycle after a stall.
    uhr_pkg::uhr_dn_beat_t mem [2];
    uhr_pkg::uhr_dn_beat_t next_mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       next_wr_ptr;
    logic       next_rd_ptr;
    logic [1:0] next_count;
    logic       push;
    logic       pop;

    assign s_ready = (count != 2'h2);
    assign m_valid = (count != 2'h0);
    assign m_beat  = mem[rd_ptr];
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = s_beat;
            next_wr_ptr      = !wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = !rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            mem    <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule
`default_nettype wire

//--- verilog/uhr_hub_ctrl.sv
`default_nettype none
// Functional notes
// [R1] Read ids and options from SPI EEPROM before touching the upstream bus.
// [R2] Once loaded and with bus power sensed, enable D+ pull-up, await reset.
// [R3] During upstream bus reset, chirp to announce high-speed capability.
// [R4] Answering host chirp sequence: enter high speed, drop the D+ pull-up.
// [R5] No answering chirp: run as a plain full-speed hub.
// [R6] Every bus reset leaves address and configuration value at zero.
// [R7] Host sets address then configuration; an address change unconfigures.
// [R8] Configured HS hub starts single-TT; alt setting 1 selects multi-TT.
// [R9] Full hub function only once configured.
// [R10] Multi-TT: each full-speed port handled on its own, own bandwidth.
// [R11] Single-TT: traffic for any FS/LS port goes to all FS/LS ports.
// [R12] High-speed hub routes FS/LS ports through a transaction translator.
// [R13] High-speed device on high-speed hub goes through repeater only.
// [R14] Full-speed hub runs HS devices at full speed, others at own speed.
// [R15] SIE does stuffing, CRC, handshakes, tokens, address match alone.
// [R16] Controller answers SETUP, moves FIFOs, suspend, toggles, port power.
// [R17] Repeater links same-speed ports only, changing at packet edges.
// [R18] Repeater enters and leaves suspend orderly, passing remote wakeup.
// [R19] Until configured, ports are unpowered with SE0 driven; then released.
// [R20] With bus power sense low, keep the pull-up off and stay detached.
module uhr_hub_ctrl #(
    parameter int CHIRP_CYCLES = uhr_pkg::CHIRP_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     upstream_vbus_sense,
    input  wire logic                     up_se0_line,
    input  wire logic                     up_k_line,
    output logic                          ee_cs_n,
    output logic                          ee_sck,
    output logic                          ee_mosi,
    input  wire logic                     ee_miso,
    output logic                          cfg_loaded,
    output uhr_pkg::uhr_ee_cfg_t          ee_cfg,
    output logic                          dp_pullup_en,
    output logic                          chirp_k_tx,
    output logic                          hs_mode,
    input  wire logic                     req_set_address,
    input  wire logic [6:0]               req_address,
    input  wire logic                     req_set_config,
    input  wire logic [7:0]               req_config,
    input  wire logic                     req_set_interface,
    input  wire logic [7:0]               req_alt,
    output logic [6:0]                    dev_address,
    output logic [7:0]                    dev_config,
    output logic                          multi_tt,
    input  wire uhr_pkg::uhr_speed_t [3:0] port_speed,
    output logic [3:0]                    port_via_tt,
    output logic [3:0]                    port_hs_ok,
    input  wire logic [3:0]               port_power_req,
    output logic [3:0]                    port_power_en,
    output logic [3:0]                    port_se0_drive,
    input  wire logic                     suspend_req,
    input  wire logic [3:0]               dn_resume_line,
    output logic                          up_resume_tx,
    output logic                          suspended,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire uhr_pkg::uhr_beat_t       in_beat,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output uhr_pkg::uhr_dn_beat_t         out_beat
);
    typedef enum logic [2:0] {
        UHR_L_LOAD   = 3'b000,
        UHR_L_DETACH = 3'b001,
        UHR_L_ATTACH = 3'b010,
        UHR_L_CHIRP  = 3'b011,
        UHR_L_WAIT   = 3'b100,
        UHR_L_HS     = 3'b101,
        UHR_L_FS     = 3'b110
    } uhr_link_t;

    localparam logic [31:0] CHIRP_LAST = 32'(CHIRP_CYCLES - 1);

    function automatic logic is_slow(input uhr_pkg::uhr_speed_t s);
        return (s == uhr_pkg::UHR_SPD_FS) || (s == uhr_pkg::UHR_SPD_LS);
    endfunction

    // Pins from outside the clock domain pass two flops before use.
    logic [7:0] sync1;
    logic [7:0] sync2;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= {dn_resume_line, ee_miso, up_k_line, up_se0_line,
                      upstream_vbus_sense};
            sync2 <= sync1;
        end
    end
    logic vbus;
    logic se0;
    logic kline;
    logic miso;
    assign vbus  = sync2[0];
    assign se0   = sync2[1];
    assign kline = sync2[2];
    assign miso  = sync2[3];

    // EEPROM read: command, start address, then the configuration bytes.
    logic [1:0]  div;
    logic [6:0]  bitn;
    logic [15:0] cmd_sh;
    logic [63:0] rd_sh;
    logic        ee_busy;
    logic [1:0]  next_div;
    logic [6:0]  next_bitn;
    logic [15:0] next_cmd_sh;
    logic [63:0] next_rd_sh;
    logic        next_ee_busy;
    logic        next_sck;
    logic        next_loaded;
    logic        tick;
    assign tick = (div == uhr_pkg::SCK_HALF);

    always_comb begin
        next_div     = tick ? 2'h0 : div + 2'h1;
        next_bitn    = bitn;
        next_cmd_sh  = cmd_sh;
        next_rd_sh   = rd_sh;
        next_ee_busy = ee_busy;
        next_sck     = ee_sck;
        next_loaded  = cfg_loaded;
        if (ee_busy && tick) begin
            if (!ee_sck) begin
                next_sck = 1'b1;
            end else begin
                next_sck    = 1'b0;
                next_cmd_sh = {cmd_sh[14:0], 1'b0};
                next_bitn   = bitn + 7'd1;
                // The synced bit lags two cycles, so take it as SCK falls.
                if (bitn >= 7'd16) begin
                    next_rd_sh = {rd_sh[62:0], miso};
                end
                if (bitn == 7'(uhr_pkg::EE_BITS - 1)) begin
                    next_ee_busy = 1'b0;
                    next_loaded  = 1'b1; // [R1]
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div        <= 2'h0;
            bitn       <= 7'h00;
            cmd_sh     <= {uhr_pkg::EE_READ_CMD, uhr_pkg::EE_START_ADDR};
            rd_sh      <= 64'h0;
            ee_busy    <= 1'b1;
            ee_sck     <= 1'b0;
            cfg_loaded <= 1'b0;
        end else begin
            div        <= next_div;
            bitn       <= next_bitn;
            cmd_sh     <= next_cmd_sh;
            rd_sh      <= next_rd_sh;
            ee_busy    <= next_ee_busy;
            ee_sck     <= next_sck;
            cfg_loaded <= next_loaded;
        end
    end
    assign ee_cs_n = !ee_busy;
    assign ee_mosi = cmd_sh[15];
    assign ee_cfg  = rd_sh;

    // Upstream attach and speed negotiation.
    uhr_link_t   link;
    uhr_link_t   next_link;
    logic [31:0] tmr;
    logic [31:0] next_tmr;
    logic [2:0]  kj;
    logic [2:0]  next_kj;
    logic        k_prev;
    logic        reset_rise;
    logic        se0_prev;
    logic        fs_only;
    assign fs_only    = ee_cfg.options[uhr_pkg::OPT_FS_ONLY];
    assign reset_rise = se0 && !se0_prev;

    always_comb begin
        next_link = link;
        next_tmr  = tmr;
        next_kj   = kj;
        case (link)
            UHR_L_LOAD:   if (cfg_loaded) next_link = UHR_L_DETACH; // [R1]
            UHR_L_DETACH: if (vbus) next_link = UHR_L_ATTACH; // [R2]
            UHR_L_ATTACH: begin
                if (se0) begin
                    next_link = fs_only ? UHR_L_FS : UHR_L_CHIRP;
                    next_tmr  = 32'h0;
                end
            end
            UHR_L_CHIRP: begin
                next_tmr = tmr + 32'h1;
                if (tmr == CHIRP_LAST) begin
                    next_link = UHR_L_WAIT; // [R3]
                    next_kj   = 3'h0;
                end
            end
            UHR_L_WAIT: begin
                if (kline != k_prev) next_kj = kj + 3'h1;
                if (kj == uhr_pkg::HOST_KJ_EDGES) begin
                    next_link = UHR_L_HS; // [R4]
                end else if (!se0) begin
                    next_link = UHR_L_FS; // [R5]
                end
            end
            UHR_L_HS, UHR_L_FS: begin
                if (reset_rise) begin
                    next_link = fs_only ? UHR_L_FS : UHR_L_CHIRP;
                    next_tmr  = 32'h0;
                end
            end
            default: next_link = UHR_L_LOAD;
        endcase
        if (!vbus && link != UHR_L_LOAD) begin
            next_link = UHR_L_DETACH; // [R20]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link     <= UHR_L_LOAD;
            tmr      <= 32'h0;
            kj       <= 3'h0;
            k_prev   <= 1'b0;
            se0_prev <= 1'b0;
        end else begin
            link     <= next_link;
            tmr      <= next_tmr;
            kj       <= next_kj;
            k_prev   <= kline;
            se0_prev <= se0;
        end
    end
    // The pull-up stays on while chirping; it drops once HS is agreed or bus power is lost.
    assign dp_pullup_en = (link == UHR_L_ATTACH) || (link == UHR_L_CHIRP)
                          || (link == UHR_L_WAIT) || (link == UHR_L_FS);
    assign chirp_k_tx   = (link == UHR_L_CHIRP); // [R3]
    assign hs_mode      = (link == UHR_L_HS); // [R4]

    // Device state, fed by requests the SIE and control logic decoded.
    logic       bus_reset;
    logic       configured;
    logic [6:0] next_address;
    logic [7:0] next_config;
    logic       next_multi;
    assign bus_reset  = reset_rise || (link == UHR_L_DETACH); // [R15]
    assign configured = (dev_config != uhr_pkg::CFG_RESET);

    always_comb begin
        next_address = dev_address;
        next_config  = dev_config;
        next_multi   = multi_tt;
        if (bus_reset) begin
            next_address = uhr_pkg::ADDR_RESET; // [R6]
            next_config  = uhr_pkg::CFG_RESET;
            next_multi   = 1'b0;
        end else if (req_set_address) begin // [R16]
            next_address = req_address;
            if (req_address != dev_address) begin
                next_config = uhr_pkg::CFG_RESET; // [R7]
                next_multi  = 1'b0;
            end
        end else if (req_set_config) begin
            next_config = req_config; // [R7]
            next_multi  = 1'b0; // [R8]
        end else if (req_set_interface && configured && hs_mode) begin
            next_multi = (req_alt == uhr_pkg::ALT_MULTI_TT) // [R8]
                && !ee_cfg.options[uhr_pkg::OPT_SINGLE_TT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_address <= uhr_pkg::ADDR_RESET;
            dev_config  <= uhr_pkg::CFG_RESET;
            multi_tt    <= 1'b0;
        end else begin
            dev_address <= next_address;
            dev_config  <= next_config;
            multi_tt    <= next_multi;
        end
    end

    // Per-port routing and port release.
    always_comb begin
        for (int i = 0; i < uhr_pkg::PORTS; i++) begin
            port_via_tt[i] = hs_mode && is_slow(port_speed[i]); // [R12] [R13]
            port_hs_ok[i]  = hs_mode; // [R14]
        end
    end
    assign port_power_en  = configured ? port_power_req : 4'h0; // [R19]
    assign port_se0_drive = configured ? 4'h0 : 4'hF; // [R19]

    // Downstream data path; the port mask is fixed at each packet start.
    logic       in_pkt;
    logic       next_in_pkt;
    logic [3:0] pkt_mask;
    logic [3:0] next_pkt_mask;
    logic [3:0] start_mask;
    logic [3:0] slow_ports;
    logic [3:0] onehot;
    logic       buf_ready;
    logic       fire;
    uhr_pkg::uhr_dn_beat_t dn_beat;

    always_comb begin
        onehot     = 4'h1 << in_beat.port;
        slow_ports = 4'h0;
        for (int i = 0; i < uhr_pkg::PORTS; i++) begin
            slow_ports[i] = is_slow(port_speed[i]);
        end
        if (hs_mode && is_slow(port_speed[in_beat.port]) && !multi_tt) begin
            start_mask = slow_ports; // [R11]
        end else begin
            start_mask = onehot; // [R10] [R13] [R14]
        end
    end

    // Suspend is entered only while in_pkt is low, so it can begin in the cycle that takes a packet's first beat.
    assign in_ready = buf_ready && configured && !suspended; // [R9]
    assign fire     = in_valid && in_ready;
    assign dn_beat  = '{mask: in_pkt ? pkt_mask : start_mask,
                        data: in_beat.data, last: in_beat.last};

    always_comb begin
        next_in_pkt   = in_pkt;
        next_pkt_mask = pkt_mask;
        if (fire) begin
            next_in_pkt = !in_beat.last; // [R17]
            if (!in_pkt) next_pkt_mask = start_mask; // [R17]
        end
    end

    logic next_susp;
    always_comb begin
        next_susp = suspended;
        if (!suspended && suspend_req && !in_pkt) next_susp = 1'b1; // [R18]
        if (suspended && !suspend_req) next_susp = 1'b0; // [R18]
        if (bus_reset) next_susp = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_pkt       <= 1'b0;
            pkt_mask     <= 4'h0;
            suspended    <= 1'b0;
            up_resume_tx <= 1'b0;
        end else begin
            in_pkt       <= next_in_pkt;
            pkt_mask     <= next_pkt_mask;
            suspended    <= next_susp;
            up_resume_tx <= suspended && (sync2[7:4] != 4'h0); // [R18]
        end
    end

    uhr_buf2 u_buf (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .s_valid (fire),
        .s_ready (buf_ready),
        .s_beat  (dn_beat),
        .m_valid (out_valid),
        .m_ready (out_ready),
        .m_beat  (out_beat)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_no_attach_early: assert property (!cfg_loaded |-> !dp_pullup_en) // [R1]
        else $error("Pull-up enabled before EEPROM load.");
    a_attach_on_vbus: assert property ( // [R2]
        link == UHR_L_DETACH && vbus |=> dp_pullup_en)
        else $error("No attach after bus power seen.");
    a_chirp_length: assert property ( // [R3]
        $rose(chirp_k_tx) |-> chirp_k_tx [*8])
        else $error("Device chirp ended too early.");
    a_hs_pullup_off: assert property (hs_mode |-> !dp_pullup_en) // [R4]
        else $error("Pull-up on in high speed.");
    a_fs_fallback: assert property ( // [R5]
        vbus && link == UHR_L_WAIT && !se0 && kj != uhr_pkg::HOST_KJ_EDGES
        |=> link == UHR_L_FS)
        else $error("No full-speed fallback.");
    a_reset_clears: assert property ( // [R6]
        bus_reset |=> dev_address == 7'h00 && dev_config == 8'h00)
        else $error("Bus reset left device state.");
    a_addr_unconf: assert property ( // [R7]
        !bus_reset && req_set_address && req_address != dev_address
        |=> !configured)
        else $error("Address change kept configuration.");
    a_multi_needs_hs: assert property ( // [R8]
        multi_tt |-> hs_mode && configured)
        else $error("Multi-TT without configured HS hub.");
    a_unconf_stall: assert property (!configured |-> !in_ready) // [R9]
        else $error("Data taken while unconfigured.");
    a_port_se0: assert property ( // [R19]
        !configured |-> port_se0_drive == 4'hF && port_power_en == 4'h0)
        else $error("Ports released before configuration.");
    a_vbus_detach: assert property (!vbus |=> !dp_pullup_en) // [R20]
        else $error("Pull-up on without bus power.");
    a_mask_held: assert property ( // [R17]
        fire && in_pkt |-> dn_beat.mask == pkt_mask)
        else $error("Port link changed inside a packet.");

    c_hs_reached:  cover property ($rose(hs_mode));
    c_fs_reached:  cover property (link == UHR_L_WAIT ##1 link == UHR_L_FS);
    c_multi_tt:    cover property ($rose(multi_tt));
    c_buf_full:    cover property (out_valid && !out_ready && !buf_ready);
endmodule
`default_nettype wire

//--- verilog/uhr_pkg.sv
`default_nettype none
package uhr_pkg;
    localparam int          PORTS         = 4;
    localparam logic [7:0]  EE_READ_CMD   = 8'h03;
    localparam logic [7:0]  EE_START_ADDR = 8'h00;
    localparam int          EE_BYTES      = 8;
    localparam int          EE_BITS       = 16 + 8 * EE_BYTES;
    localparam logic [1:0]  SCK_HALF      = 2'h1;
    localparam int          CLK_KHZ       = 10000;
    localparam int          CHIRP_US      = 1000;
    localparam int          CHIRP_CYC     = (CHIRP_US * CLK_KHZ + 999) / 1000;
    localparam logic [2:0]  HOST_KJ_EDGES = 3'h6;
    localparam logic [6:0]  ADDR_RESET    = 7'h00;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  ALT_MULTI_TT  = 8'h01;
    localparam int          OPT_SINGLE_TT = 0;
    localparam int          OPT_FS_ONLY   = 1;

    typedef enum logic [1:0] {
        UHR_SPD_NONE = 2'b00,
        UHR_SPD_FS   = 2'b01,
        UHR_SPD_LS   = 2'b10,
        UHR_SPD_HS   = 2'b11
    } uhr_speed_t;

    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [15:0] device_release_code;
        logic [15:0] options;
    } uhr_ee_cfg_t;

    typedef struct packed {
        logic [1:0] port;
        logic [7:0] data;
        logic       last;
    } uhr_beat_t;

    typedef struct packed {
        logic [PORTS-1:0] mask;
        logic [7:0]       data;
        logic             last;
    } uhr_dn_beat_t;
endpackage
`default_nettype wire
